// ===== design/siu_pkg.sv
// siu_pkg: register map, field layout, reset values and modes of the system integration unit
package siu_pkg;

  // ---------------------------------------------------------------
  // register indices (byte address = 4 * index)
  // ---------------------------------------------------------------
  localparam logic [5:0] SIU_IDX_CTRL  = 6'h00;
  localparam logic [5:0] SIU_IDX_RSTS  = 6'h01;
  localparam logic [5:0] SIU_IDX_PCG   = 6'h0c;
  localparam logic [5:0] SIU_IDX_SHORT_ADDR_LOW_FIELD  = 6'h0e;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int SIU_CTRL_SWRST   = 0;
  localparam int SIU_CTRL_WAIT    = 1;
  localparam int SIU_CTRL_STOP    = 2;
  localparam int SIU_CTRL_CLKDIS  = 3;
  localparam int SIU_CTRL_DBGEN   = 4;
  localparam int SIU_RSTS_POR     = 2;
  localparam int SIU_RSTS_EXT     = 3;
  localparam int SIU_RSTS_WDOG    = 4;
  localparam int SIU_RSTS_SWR     = 5;
  localparam logic [15:0] SIU_RSTS_MASK = 16'h003c;
  localparam logic [4:0]  SIU_CTRL_MASK = 5'h1e;

  // ---------------------------------------------------------------
  // reset values and timing
  // ---------------------------------------------------------------
  localparam logic [15:0] SIU_PCG_RST   = 16'hffff;
  localparam logic [15:0] SIU_SHORT_ADDR_LOW_FIELD_RST  = 16'hffff;
  localparam logic [15:0] SIU_RSTS_RST  = 16'h0004;   // power-on flag only
  localparam logic [4:0]  SIU_CTRL_RST  = 5'h00;
  localparam int          SIU_CLK_DIV   = 2;    // master clock divided by two
  localparam int          SIU_MCLK_MAX_MHZ = 120;
  localparam int          SIU_OCLK_MAX_MHZ = SIU_MCLK_MAX_MHZ / SIU_CLK_DIV;

  // power modes
  typedef enum logic [1:0] {SIU_RUN, SIU_WAIT, SIU_STOP} siu_mode_e;

endpackage

// ===== design/siu_clk_if.sv
// siu_clk_if: enables and derived clocks between register logic and clock gating
interface siu_clk_if #(parameter int N = 16);
  logic [N-1:0] per_en;
  logic         core_run;
  logic         per_run;
  logic         core_clk;
  logic [N-1:0] per_clk;
  modport ctl (output per_en, output core_run, output per_run,
               input core_clk, input per_clk);
  modport gen (input per_en, input core_run, input per_run,
               output core_clk, output per_clk);
endinterface

// ===== design/siu_clk_gate.sv
// siu_clk_gate: divide-by-two clock generation with whole-pulse per-peripheral gating
module siu_clk_gate
  import siu_pkg::*;
#(
  parameter int N = 16
) (
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic sys_rst,
  // enables in, clocks out
  siu_clk_if.gen    cif
);

  initial begin
    if (N < 1 || N > 16) $error("siu_clk_gate: N must be 1..16");
  end

  typedef struct packed {
    logic         phase;
    logic         core_clk;
    logic [N-1:0] per_clk;
  } siu_gate_s;

  siu_gate_s st_r;
  siu_gate_s st_nxt;

  // ---------------------------------------------------------------
  // clock outputs
  // ---------------------------------------------------------------
  // each output is a flop, so every high or low phase is a whole cycle
  always_comb begin
    st_nxt          = st_r;
    st_nxt.phase    = ~st_r.phase;                              // half master rate
    st_nxt.core_clk = cif.core_run & ~st_r.phase;
    st_nxt.per_clk  = {N{cif.per_run & ~st_r.phase}} & cif.per_en;
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign cif.core_clk = st_r.core_clk;
  assign cif.per_clk  = st_r.per_clk;

endmodule

// ===== design/siu_top.sv
// siu_top: reset cause capture, clock gating control and short address register over APB
// ---------------------------------------------------------------
// ---------------------------------------------------------------
module siu_top
  import siu_pkg::*;
#(
  parameter int N_PER = 16
) (
  // clock and power-on reset
  input  wire logic              ref_clk,
  input  wire logic              sys_rst,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  // reset sources
  input  wire logic              ext_rst_n,
  input  wire logic              wdog_rst,
  // wake and system reset
  input  wire logic              irq_unmasked,
  output logic                   sys_reset_out,
  // derived clocks and short address
  output logic                   core_clk,
  output logic [N_PER-1:0]       periph_clk,
  output logic [15:0]            short_addr_low
);

  initial begin
    if (N_PER != 16) $error("siu_top: N_PER must be 16");
  end

  typedef struct packed {
    logic [1:0]  ext_sync;
    logic        ext_prev;
    logic [15:0] rsts;
    logic [15:0] pcg;
    logic [15:0] short_addr_low_field;
    logic [4:0]  ctrl;
    siu_mode_e   mode;
    logic        rst_out;
    logic [31:0] rdata;
  } siu_state_s;

  siu_state_s st_r;
  siu_state_s st_nxt;

  siu_clk_if #(.N(N_PER)) cif ();

  // ---------------------------------------------------------------
  // apb decode
  // ---------------------------------------------------------------
  logic       acc;
  logic       wr;
  logic [5:0] idx;
  logic       mapped;
  logic       ext_now;
  logic       ext_evt;
  logic       sw_evt;
  logic [15:0] wd;

  // true for the four mapped word indices
  function automatic logic is_mapped(input logic [5:0] i);
    is_mapped = (i == SIU_IDX_CTRL) || (i == SIU_IDX_RSTS) ||
                (i == SIU_IDX_PCG)  || (i == SIU_IDX_SHORT_ADDR_LOW_FIELD);
  endfunction

  // write-0-sets, write-1-clears for one cause flag
  function automatic logic flag_wr(input logic cur, input logic wbit, input logic hit);
    flag_wr = hit ? ~wbit : cur;
  endfunction

  assign acc     = psel & penable;
  assign wr      = acc & pwrite;
  assign idx     = paddr[7:2];
  assign mapped  = is_mapped(idx) && (paddr[1:0] == 2'b00);
  assign wd      = pwdata[15:0];
  assign ext_now = ~st_r.ext_sync[1];
  assign ext_evt = ext_now & ~st_r.ext_prev;
  assign sw_evt  = wr && mapped && idx == SIU_IDX_CTRL && wd[SIU_CTRL_SWRST];

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    st_nxt          = st_r;
    st_nxt.ext_sync = {st_r.ext_sync[0], ext_rst_n};
    st_nxt.ext_prev = ext_now;
    st_nxt.rst_out  = 1'b0;

    // register writes
    if (wr && mapped) begin
      unique case (idx)
        SIU_IDX_CTRL: begin
          st_nxt.ctrl = wd[4:0] & SIU_CTRL_MASK;
          if (wd[SIU_CTRL_STOP]) begin
            st_nxt.mode = SIU_STOP;
          end else if (wd[SIU_CTRL_WAIT]) begin
            st_nxt.mode = SIU_WAIT;
          end
        end
        SIU_IDX_RSTS: begin
          // only bits 5..2 are writable
          st_nxt.rsts[SIU_RSTS_POR]  = flag_wr(st_r.rsts[SIU_RSTS_POR], wd[SIU_RSTS_POR], 1'b1);
          st_nxt.rsts[SIU_RSTS_EXT]  = flag_wr(st_r.rsts[SIU_RSTS_EXT], wd[SIU_RSTS_EXT], 1'b1);
          st_nxt.rsts[SIU_RSTS_WDOG] = flag_wr(st_r.rsts[SIU_RSTS_WDOG], wd[SIU_RSTS_WDOG],
                                               1'b1);
          st_nxt.rsts[SIU_RSTS_SWR]  = flag_wr(st_r.rsts[SIU_RSTS_SWR], wd[SIU_RSTS_SWR], 1'b1);
        end
        SIU_IDX_PCG:  st_nxt.pcg  = wd;
        SIU_IDX_SHORT_ADDR_LOW_FIELD: st_nxt.short_addr_low_field = wd;
        default:      st_nxt.pcg  = st_r.pcg;
      endcase
    end

    // unmasked interrupt resumes run from wait or stop
    if (irq_unmasked && st_r.mode != SIU_RUN) begin
      st_nxt.mode = SIU_RUN;
      st_nxt.ctrl[SIU_CTRL_WAIT] = 1'b0;
      st_nxt.ctrl[SIU_CTRL_STOP] = 1'b0;
    end

    // system resets: the event wins over a same-cycle software write
    if (ext_evt || wdog_rst || sw_evt) begin
      st_nxt.pcg     = SIU_PCG_RST;
      st_nxt.short_addr_low_field    = SIU_SHORT_ADDR_LOW_FIELD_RST;
      st_nxt.ctrl    = SIU_CTRL_RST;
      st_nxt.mode    = SIU_RUN;
      st_nxt.rst_out = 1'b1;
      st_nxt.rsts[SIU_RSTS_POR] = 1'b0;
      // watchdog and external flags kept unless set here
      st_nxt.rsts[SIU_RSTS_SWR] = sw_evt;
      if (ext_evt) begin
        st_nxt.rsts[SIU_RSTS_EXT] = 1'b1;
      end
      if (wdog_rst) begin
        st_nxt.rsts[SIU_RSTS_WDOG] = 1'b1;
      end
    end
    st_nxt.rsts = st_nxt.rsts & SIU_RSTS_MASK;

    // read data registered for the access phase; unaligned reads give zero
    st_nxt.rdata = '0;
    if (psel && !penable && !pwrite && paddr[1:0] == 2'b00) begin
      unique case (paddr[7:2])
        SIU_IDX_CTRL: st_nxt.rdata = {27'h000_0000, st_r.ctrl};
        SIU_IDX_RSTS: st_nxt.rdata = {16'h0000, st_r.rsts};
        SIU_IDX_PCG:  st_nxt.rdata = {16'h0000, st_r.pcg};
        SIU_IDX_SHORT_ADDR_LOW_FIELD: st_nxt.rdata = {16'h0000, st_r.short_addr_low_field};
        default:      st_nxt.rdata = '0;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // state register; sys_rst is the power-on reset
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      st_r          <= '0;
      st_r.ext_sync <= 2'b11;
      st_r.rsts     <= SIU_RSTS_RST;             // power-on flag only
      st_r.pcg      <= SIU_PCG_RST;
      st_r.short_addr_low_field     <= SIU_SHORT_ADDR_LOW_FIELD_RST;
      st_r.ctrl     <= SIU_CTRL_RST;
      st_r.mode     <= SIU_RUN;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ---------------------------------------------------------------
  // clock control
  // ---------------------------------------------------------------
  // stop or global disable halt all; wait halts only the core
  assign cif.per_en   = st_r.pcg;
  assign cif.core_run = (st_r.mode == SIU_RUN) && !st_r.ctrl[SIU_CTRL_CLKDIS];
  assign cif.per_run  = (st_r.mode != SIU_STOP) && !st_r.ctrl[SIU_CTRL_CLKDIS];

  siu_clk_gate #(.N(N_PER)) u_gate (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .cif     (cif.gen)
  );

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign prdata         = st_r.rdata;
  assign pready         = 1'b1;
  assign pslverr        = acc & ~mapped;
  assign sys_reset_out  = st_r.rst_out;
  assign core_clk       = cif.core_clk;
  assign periph_clk     = cif.per_clk;
  assign short_addr_low = st_r.short_addr_low_field;

endmodule

// ===== dv/siu_monitor.sv
// siu_monitor: port-level checks of siu_top
module siu_monitor
  import siu_pkg::*;
#(
  parameter int N_PER = 16
) (
  // clock and reset
  input wire logic             ref_clk,
  input wire logic             sys_rst,
  // apb
  input wire logic             psel,
  input wire logic             penable,
  input wire logic             pwrite,
  input wire logic [7:0]       paddr,
  input wire logic [31:0]      pwdata,
  input wire logic [31:0]      prdata,
  input wire logic             pready,
  input wire logic             pslverr,
  // resets, wake and clocks
  input wire logic             ext_rst_n,
  input wire logic             wdog_rst,
  input wire logic             irq_unmasked,
  input wire logic             sys_reset_out,
  input wire logic             core_clk,
  input wire logic [N_PER-1:0] periph_clk,
  input wire logic [15:0]      short_addr_low
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  // ----------------
  // checks
  // ----------------
  // access phase and mapped address
  logic acc;
  logic hit;
  assign acc = psel && penable;
  assign hit = paddr inside {8'h00, 8'h04, 8'h30, 8'h38};
  ready_high_a: assert property (acc |-> pready) else $error("pready low");
  addr_err_a: assert property (acc |-> pslverr == !hit) else $error("pslverr wrong");
  upper_zero_a: assert property (acc && !pwrite |-> prdata[31:16] == 16'h0000)
    else $error("upper read bits set");
  rsvd_zero_a: assert property (acc && !pwrite && paddr == 8'h04 |->
    (prdata[15:0] & 16'hffc3) == 16'h0000) else $error("reserved status bit set");
  short_wr_a: assert property (acc && pwrite && paddr == 8'h38 && !wdog_rst |=>
    short_addr_low == $past(pwdata[15:0])) else $error("short address not stored");
  init_val_a: assert property ($fell(sys_rst) |-> short_addr_low == 16'hffff
    && !core_clk && periph_clk == '0) else $error("bad state after reset");
  core_half_a: assert property (core_clk |=> !core_clk) else $error("core clock not halved");
  per_pulse_a: assert property (|periph_clk |=> periph_clk == '0)
    else $error("peripheral pulse too long");
  wdog_out_a: assert property (wdog_rst |-> ##[1:2] sys_reset_out)
    else $error("no reset pulse after watchdog");
  out_pulse_a: assert property (sys_reset_out |=> !sys_reset_out)
    else $error("reset pulse too long");
  cover property (wdog_rst);
  cover property (acc && pslverr);
  cover property ($fell(ext_rst_n));
endmodule

bind siu_top siu_monitor #(.N_PER(N_PER)) u_mon (.ref_clk, .sys_rst, .psel, .penable, .pwrite,
  .paddr, .pwdata, .prdata, .pready, .pslverr, .ext_rst_n, .wdog_rst, .irq_unmasked,
  .sys_reset_out, .core_clk, .periph_clk, .short_addr_low);

// ===== dv/siu_top_bench.sv
// siu_top_bench: directed scenarios for the system integration unit
module siu_top_bench;
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------
  // signals
  // ----------------
  logic        ref_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic        ext_rst_n = 1'b1;
  logic        wdog_rst = 1'b0;
  logic        irq_unmasked = 1'b0;
  logic [31:0] prdata, q;
  logic        pready, pslverr, sys_reset_out, core_clk, e;
  logic [15:0] periph_clk, short_addr_low;
  int          fails = 0, samples_checked = 0, cyc = 0, pulses = 0;

`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin fails++; \
  $display("Error at %0t got %h expected %h", $time, (a), (b)); end end

  // clock
  always #25 ref_clk = ~ref_clk;

  siu_top #(.N_PER(16)) u_dut (.ref_clk, .sys_rst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .ext_rst_n, .wdog_rst, .irq_unmasked,
    .sys_reset_out, .core_clk, .periph_clk, .short_addr_low);

  // reset pulse count and hang guard
  always @(posedge ref_clk) begin
    cyc++;
    if (sys_reset_out === 1'b1) pulses++;
    if (cyc == 5000) begin
      fails++;
      final_report();
    end
  end

  // one apb transfer, result in q and e
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] x);
    xfer(1'b0, a, 32'h0000_0000);
    `CHK(q[15:0], x)
  endtask

  // clock activity over four cycles
  task automatic meas(input logic cx, input logic [15:0] px);
    logic        cc = 1'b0;
    logic [15:0] pp = 16'h0000;
    repeat (3) @(posedge ref_clk);
    repeat (4) begin
      @(posedge ref_clk);
      cc |= core_clk;
      pp |= periph_clk;
    end
    `CHK({cc, pp}, {cx, px})
  endtask

  task automatic wait_n(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  // ----------------
  // scenarios
  // ----------------
  task automatic t_reset_values;
    rd(8'h04, 16'h0004);
    rd(8'h30, 16'hffff);
    rd(8'h38, 16'hffff);
    xfer(1'b0, 8'h08, 32'h0000_0000);
    `CHK({e, q}, {1'b1, 32'h0000_0000})
  endtask

  task automatic t_status_write;
    xfer(1'b1, 8'h04, 32'h0000_003c);
    rd(8'h04, 16'h0000);
    xfer(1'b1, 8'h04, 32'h0000_ffc3);
    rd(8'h04, 16'h003c);
    xfer(1'b1, 8'h04, 32'h0000_003c);
  endtask

  task automatic t_short;
    xfer(1'b1, 8'h38, 32'hffff_1234);
    rd(8'h38, 16'h1234);
    `CHK(short_addr_low, 16'h1234)
  endtask

  task automatic t_gates;
    for (int i = 0; i < 16; i++) begin
      xfer(1'b1, 8'h30, 32'(1 << i));
      meas(1'b1, 16'(1 << i));
    end
    xfer(1'b1, 8'h30, 32'h0000_ffff);
  endtask

  task automatic t_modes;
    xfer(1'b1, 8'h00, 32'h0000_0002);
    meas(1'b0, 16'hffff);
    irq_unmasked <= 1'b1;
    wait_n(1);
    irq_unmasked <= 1'b0;
    meas(1'b1, 16'hffff);
    rd(8'h00, 16'h0000);
    xfer(1'b1, 8'h00, 32'h0000_0004);
    meas(1'b0, 16'h0000);
    irq_unmasked <= 1'b1;
    wait_n(1);
    irq_unmasked <= 1'b0;
    meas(1'b1, 16'hffff);
    xfer(1'b1, 8'h00, 32'h0000_0008);
    meas(1'b0, 16'h0000);
    xfer(1'b1, 8'h00, 32'h0000_0000);
    meas(1'b1, 16'hffff);
  endtask

  task automatic t_causes;
    wdog_rst <= 1'b1;
    wait_n(1);
    wdog_rst <= 1'b0;
    wait_n(4);
    rd(8'h04, 16'h0010);
    ext_rst_n <= 1'b0;
    wait_n(3);
    ext_rst_n <= 1'b1;
    wait_n(6);
    rd(8'h04, 16'h0018);
    xfer(1'b1, 8'h00, 32'h0000_0001);
    wait_n(3);
    rd(8'h04, 16'h0038);
    `CHK(pulses, 3)
    sys_rst <= 1'b1;
    wait_n(2);
    sys_rst <= 1'b0;
    wait_n(1);
    rd(8'h04, 16'h0004);
  endtask

  task automatic final_report;
    $display("checks %0d errors %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // main sequence
  initial begin
    wait_n(2);
    sys_rst <= 1'b0;
    wait_n(1);
    t_reset_values();
    t_status_write();
    t_short();
    t_gates();
    t_modes();
    t_causes();
    final_report();
  end
endmodule
